// [src/bax_exec.sv]
`timescale 1ns/1ns
// Contract
// - add acc and register, update carry, nibble, zero
// - select 0 to acc, 1 to register
// - shift right keeping bit 7, bit 0 to carry
// - add acc, register and carry
// - clear one selected bit, flags untouched
// - tested bit zero discards next, two cycles
// - tested bit one runs next, no flags
// - pc becomes next address plus signed offset
// - pc becomes next address plus unsigned acc
// - pc change or skip adds nop cycle
module bax_exec (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // instruction issue, same clock domain
  input wire logic instrValid,
  input bax_pkg::bax_instr_t instr,
  output logic instrReady,
  // data memory, combinational read of regAddr
  output logic [6:0] memAddr,
  input wire logic [7:0] memRdata,
  output bax_pkg::bax_wr_t memWr,
  // architectural state
  output logic [7:0] acc,
  output bax_pkg::bax_flags_t flags,
  output logic [14:0] pc,
  output logic flushCycle
);

  ////////////////////////////////////////////////////////////
  logic [7:0] acc_r, acc_nxt;
  bax_pkg::bax_flags_t flags_r, flags_nxt;
  logic [14:0] pc_r, pc_nxt;
  bax_pkg::bax_phase_t phase_r, phase_nxt;
  bax_pkg::bax_wr_t wr_r, wr_nxt;
  logic [7:0] sum;
  logic cout;
  logic nibbleOut;
  logic addCin;
  logic [7:0] result;
  logic [14:0] pcNext;
  // set by a jump: its nop cycle must not step past the target
  logic holdPc_r, holdPc_nxt;

  assign addCin = (instr.op == bax_pkg::OP_ADDC) ? flags_r.carry : 1'b0;

  bax_adder uAdder (
    .a(acc_r),
    .b(memRdata),
    .cin(addCin),
    .sum(sum),
    .cout(cout),
    .nibbleOut(nibbleOut)
  );

  ////////////////////////////////////////////////////////////
  // pc still points at the branch while it executes, so pcNext adds one step
  assign pcNext = pc_r + bax_pkg::PC_STEP;
  assign memAddr = instr.regAddr;
  // no new instruction is taken during the nop cycle
  assign instrReady = (phase_r == bax_pkg::PH_EXEC);

  always_comb begin
    acc_nxt = acc_r;
    flags_nxt = flags_r;
    pc_nxt = pc_r;
    phase_nxt = bax_pkg::PH_EXEC;
    wr_nxt = '0;
    holdPc_nxt = 1'b0;
    result = memRdata;
    case (phase_r)
      bax_pkg::PH_FLUSH: begin
        // discarded slot behaves as a nop
        if (!holdPc_r) begin
          pc_nxt = pcNext;
        end
      end
      bax_pkg::PH_EXEC: begin
        if (instrValid) begin
          pc_nxt = pcNext;
          case (instr.op)
            bax_pkg::OP_ADD, bax_pkg::OP_ADDC: begin
              result = sum;
              flags_nxt.carry = cout;
              flags_nxt.nibble = nibbleOut;
              flags_nxt.zero = (sum == 8'h00);
            end
            bax_pkg::OP_ASR: begin
              result = {memRdata[bax_pkg::MSB_POS], memRdata[7:1]};
              flags_nxt.carry = memRdata[0];
              flags_nxt.zero = (result == 8'h00);
            end
            bax_pkg::OP_BCLR: begin
              result = memRdata & ~(8'h01 << instr.bitSel);
            end
            bax_pkg::OP_BTSKZ: begin
              if (!memRdata[instr.bitSel]) begin
                phase_nxt = bax_pkg::PH_FLUSH;
              end
              // bit set: next instruction runs normally
            end
            bax_pkg::OP_JLIT: begin
              pc_nxt = pcNext + {{(15 - 9){instr.offset[8]}}, instr.offset};
              phase_nxt = bax_pkg::PH_FLUSH;
              holdPc_nxt = 1'b1;
            end
            bax_pkg::OP_JACC: begin
              pc_nxt = pcNext + {7'h00, acc_r};
              phase_nxt = bax_pkg::PH_FLUSH;
              holdPc_nxt = 1'b1;
            end
            default: begin
            end
          endcase
          // only result-producing ops steer the destination
          if (instr.op == bax_pkg::OP_ADD || instr.op == bax_pkg::OP_ADDC || instr.op == bax_pkg::OP_ASR) begin
            if (instr.destSel == bax_pkg::DEST_ACC) begin
              acc_nxt = result;
            end else begin
              wr_nxt = '{en: 1'b1, addr: instr.regAddr, data: result};
            end
          end else if (instr.op == bax_pkg::OP_BCLR) begin
            wr_nxt = '{en: 1'b1, addr: instr.regAddr, data: result};
          end
        end
      end
      default: begin
        phase_nxt = bax_pkg::PH_EXEC;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      acc_r <= bax_pkg::ACC_RESET;
      flags_r <= '0;
      pc_r <= bax_pkg::PC_RESET;
      phase_r <= bax_pkg::PH_EXEC;
      wr_r <= '0;
      holdPc_r <= 1'b0;
    end else begin
      acc_r <= acc_nxt;
      flags_r <= flags_nxt;
      pc_r <= pc_nxt;
      phase_r <= phase_nxt;
      wr_r <= wr_nxt;
      holdPc_r <= holdPc_nxt;
    end
  end

  assign acc = acc_r;
  assign flags = flags_r;
  assign pc = pc_r;
  assign memWr = wr_r;
  assign flushCycle = (phase_r == bax_pkg::PH_FLUSH);

endmodule // bax_exec

// [src/bax_pkg.sv]
package bax_pkg;

  // widths
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam int PC_W = 15;
  localparam int OFS_W = 9;
  localparam int BITSEL_W = 3;

  // field positions
  localparam int MSB_POS = 7;
  localparam int NIBBLE_POS = 4;

  // destination select codes
  localparam logic DEST_ACC = 1'b0;
  localparam logic DEST_REG = 1'b1;

  // reset values and pc step
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [14:0] PC_RESET = 15'h0000;
  localparam logic [14:0] PC_STEP = 15'h0001;

  // operation codes
  typedef enum logic [2:0] {
    OP_NOP = 3'b000,
    OP_ADD = 3'b001,
    OP_ADDC = 3'b010,
    OP_ASR = 3'b011,
    OP_BCLR = 3'b100,
    OP_BTSKZ = 3'b101,
    OP_JLIT = 3'b110,
    OP_JACC = 3'b111
  } bax_op_t;

  // execution phase
  typedef enum logic [0:0] {
    PH_EXEC = 1'b0,
    PH_FLUSH = 1'b1
  } bax_phase_t;

  // decoded instruction
  typedef struct packed {
    bax_op_t op;
    logic [6:0] regAddr;
    logic destSel;
    logic [2:0] bitSel;
    logic [8:0] offset;
  } bax_instr_t;

  // status flags
  typedef struct packed {
    logic carry;
    logic nibble;
    logic zero;
  } bax_flags_t;

  // data memory write request
  typedef struct packed {
    logic en;
    logic [6:0] addr;
    logic [7:0] data;
  } bax_wr_t;

endpackage

// [src/bax_adder.sv]
`timescale 1ns/1ns
// 8-bit adder giving carry out of bit 3 and bit 7
module bax_adder (
  // operands
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic cin,
  // results
  output logic [7:0] sum,
  output logic cout,
  output logic nibbleOut
);
  logic [4:0] low;
  logic [4:0] high;

  always_comb begin
    low = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    high = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, low[bax_pkg::NIBBLE_POS]};
    sum = {high[3:0], low[3:0]};
    cout = high[bax_pkg::NIBBLE_POS];
    nibbleOut = low[bax_pkg::NIBBLE_POS];
  end
endmodule // bax_adder

// [bench/bax_exec_asserts.sv]
`timescale 1ns/1ns
module bax_exec_asserts (
  // issue
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic instrValid,
  input bax_pkg::bax_instr_t instr,
  input wire logic instrReady,
  // state
  input wire logic [6:0] memAddr,
  input wire logic [7:0] memRdata,
  input bax_pkg::bax_wr_t memWr,
  input wire logic [7:0] acc,
  input bax_pkg::bax_flags_t flags,
  input wire logic [14:0] pc,
  input wire logic flushCycle
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // one-hot of the op taken this edge
  wire logic [7:0] op = instrValid && instrReady ? 8'h01 << instr.op : 8'h00;
  AST_ADD: assert property (op[bax_pkg::OP_ADD] && !instr.destSel |=>
    acc == $past(8'(acc + memRdata)) && flags.zero == (acc == 8'h00)) else $error("add");
  AST_ADDC: assert property (op[bax_pkg::OP_ADDC] && instr.destSel |=>
    memWr.en && memWr.data == $past(8'(acc + memRdata + flags.carry))) else $error("addc");
  AST_ASR: assert property (op[bax_pkg::OP_ASR] |=>
    flags.carry == $past(memRdata[0]) && $stable(flags.nibble)) else $error("asr");
  AST_BCLR: assert property (op[bax_pkg::OP_BCLR] |=>
    memWr.data == $past(memRdata & ~(8'h01 << instr.bitSel)) && $stable(flags)) else $error("bclr");
  AST_SKIP: assert property (op[bax_pkg::OP_BTSKZ] && !memRdata[instr.bitSel] |=>
    flushCycle && !instrReady ##1 !flushCycle) else $error("skip");
  AST_RUN: assert property (op[bax_pkg::OP_BTSKZ] && memRdata[instr.bitSel] |=>
    !flushCycle && $stable(flags)) else $error("run");
  AST_JLIT: assert property (op[bax_pkg::OP_JLIT] |=> flushCycle &&
    pc == $past(pc + 15'h0001 + {{6{instr.offset[8]}}, instr.offset})) else $error("jlit");
  AST_JACC: assert property (op[bax_pkg::OP_JACC] |=> flushCycle &&
    $stable(flags) && pc == $past(pc + 15'h0001 + acc)) else $error("jacc");
  AST_JHOLD: assert property (op[bax_pkg::OP_JLIT] || op[bax_pkg::OP_JACC] |=>
    ##1 pc == $past(pc)) else $error("jump nop moved pc");
endmodule // bax_exec_asserts
bind bax_exec bax_exec_asserts chk_u (.*);

// [bench/test_byte_alu_bit_test_branch_exec.sv]
`timescale 1ns/1ns
module test_byte_alu_bit_test_branch_exec;
  logic sys_clk = 0;
  logic rst = 1;
  logic instrValid = 0;
  logic instrReady, flushCycle, f;
  logic [6:0] memAddr;
  logic [7:0] memRdata = 8'h00, acc, ea, d, r;
  logic [14:0] pc, epc;
  logic [8:0] s;
  logic [4:0] n;
  bax_pkg::bax_instr_t instr = '0, i;
  bax_pkg::bax_wr_t memWr, ew;
  bax_pkg::bax_flags_t flags, ef;
  int n_mismatch = 0, n_compared = 0, cyc = 0;
  bax_exec dut_u (.*);
  always #50 sys_clk = ~sys_clk;
  task tally_and_finish;
    if (n_mismatch == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input logic [15:0] g, e);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %0t %h %h", $time, g, e);
    end
  endtask
  task look(input logic fl);
    @(posedge sys_clk);
    #10;
    chk(acc, ea);
    chk(flags, ef);
    chk(pc, epc);
    chk(memWr.en ? memWr : 16'h0000, ew);
    chk(memAddr, instr.regAddr);
    chk({instrReady, flushCycle}, {!fl, fl});
  endtask
  // 400 ops at two cycles at most
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_mismatch++;
      tally_and_finish;
    end
  end
  initial begin
    void'($urandom(32'h113debd1));
    {ea, ef, epc, ew} = '0;
    repeat (20) @(posedge sys_clk);
    #10 rst = 0;
    look(1'b0);
    for (int k = 0; k < 400; k++) begin
      i = 23'($urandom);
      d = 8'($urandom);
      // first pass walks every op, jump at its lowest offset
      if (k < 8) i.op = bax_pkg::bax_op_t'(k[2:0]);
      if (k == 6) i.offset = 9'h100;
      instr = i;
      memRdata = d;
      instrValid = 1;
      ew = '0;
      epc = epc + 15'h0001;
      case (i.op)
        bax_pkg::OP_ADD, bax_pkg::OP_ADDC: begin
          s = ea + d + (i.op == bax_pkg::OP_ADDC && ef.carry);
          n = ea[3:0] + d[3:0] + (i.op == bax_pkg::OP_ADDC && ef.carry);
          r = s[7:0];
          ef = {s[8], n[4], r == 8'h00};
        end
        bax_pkg::OP_ASR: begin
          r = {d[7], d[7:1]};
          ef = {d[0], ef.nibble, r == 8'h00};
        end
        bax_pkg::OP_BCLR: ew = {1'b1, i.regAddr, d & ~(8'h01 << i.bitSel)};
        bax_pkg::OP_JLIT: epc = epc + {{6{i.offset[8]}}, i.offset};
        bax_pkg::OP_JACC: epc = epc + ea;
        default: ;
      endcase
      if (i.op > bax_pkg::OP_NOP && i.op < bax_pkg::OP_BCLR) begin
        if (i.destSel) ew = {1'b1, i.regAddr, r};
        else ea = r;
      end
      f = i.op > bax_pkg::OP_BCLR && (i.op != bax_pkg::OP_BTSKZ || !d[i.bitSel]);
      look(f);
      // held instr is the discarded slot, must be ignored; a jump keeps its target
      if (f) begin
        ew = '0;
        if (i.op == bax_pkg::OP_BTSKZ) epc = epc + 15'h0001;
        look(1'b0);
      end
    end
    tally_and_finish;
  end
endmodule // test_byte_alu_bit_test_branch_exec
